// ### hdl/host_port_cfg.svh
// host port timing constants and grant reset level
// assumes a 125 MHz clk; included by host_port_pkg and the port module
// Function
// [RQ1] mastership passes via request and grant lines
// [RQ2] host asserts select and request first
// [RQ3] host strobes only after grant returned
// [RQ4] granted access reaches memory or io registers
// [RQ5] request and grant held through whole access
// [RQ6] first access uses address outside shared space
// [RQ7] host drives high address bit during grant
// [RQ8] request setup needed only for current cycle
// [RQ9] priority access asserted synchronously, released freely
// [RQ10] open-drain and active-drive ready styles
// [RQ11] ready low when select and request low
// [RQ12] ready released or high after grant
// [RQ13] active ready undriven when select or request high
// [RQ14] read holds ready low for read wait
// [RQ15] read data valid before ready release
// [RQ16] host holds read strobe until ready release
// [RQ17] write holds ready low for write wait
// [RQ18] host holds write strobe until ready release
// [RQ19] write address and data taken on strobe rise
// [RQ20] ready released on a clock edge
// [RQ21] host drops request, device withdraws grant
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
`define CLK_PERIOD_PS      8000
`define READ_WAIT_PS       53000
`define READ_WAIT_CYC      ((`READ_WAIT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_WAIT_PS      15000
`define WRITE_WAIT_CYC     ((`WRITE_WAIT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define GRANT_DELAY_CYC    2
`define RESET_GRANT_N      1'b1
`endif

// ### hdl/host_port_pkg.sv
// types for the host bus hand-off port
// assumes host_port_cfg.svh is on the include path
`include "host_port_cfg.svh"
package host_port_pkg;
	typedef enum logic [5:0]
	{
		ST_IDLE   = 6'b000001,
		ST_HOLD   = 6'b000010,
		ST_GRANT  = 6'b000100,
		ST_RWAIT  = 6'b001000,
		ST_WWAIT  = 6'b010000,
		ST_DONE   = 6'b100000
	} port_state_type;

	function automatic logic both_low(input logic a_n, input logic b_n);
		both_low = !a_n && !b_n;
	endfunction : both_low
endpackage : host_port_pkg

// ### hdl/sync2.sv
// two-flop synchroniser for a vector of pin inputs
// assumes inputs are asynchronous to clk; reset value is a parameter
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_q <= INIT;
			q      <= INIT;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : sync2
`default_nettype wire

// ### hdl/host_bus_handoff_async_port.sv
// host bus hand-off and asynchronous host access port
// assumes host pins asynchronous; memory behind it answers in one cycle
`timescale 1ns/10ps
`default_nettype none
`include "host_port_cfg.svh"
module host_bus_handoff_async_port
	import host_port_pkg::*;
#(
	parameter int AW = 32,
	parameter int DW = 48,
	parameter int NPROC = 4
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             chip_select_n,
	input  wire logic             host_bus_request_n,
	input  wire logic             host_read_n,
	input  wire logic             host_write_n,
	input  wire logic [AW-1:0]    host_addr,
	input  wire logic [DW-1:0]    host_wdata,
	input  wire logic             ready_active_drive,
	input  wire logic [NPROC-1:0] processor_bus_request_lines,
	input  wire logic             core_priority_access_n,
	input  wire logic             bus_idle,
	output logic                  host_bus_grant_n,
	output logic                  host_ready_o,
	output logic                  host_ready_oe,
	output logic [DW-1:0]         host_rdata,
	output logic                  host_rdata_oe,
	output logic                  mem_rd,
	output logic                  mem_wr,
	output logic [AW-1:0]         mem_addr,
	output logic [DW-1:0]         mem_wdata,
	input  wire logic [DW-1:0]    mem_rdata
);
	localparam logic [7:0] RD_WAIT = 8'(`READ_WAIT_CYC);
	localparam logic [7:0] WR_WAIT = 8'(`WRITE_WAIT_CYC);
	localparam logic [7:0] GR_WAIT = 8'(`GRANT_DELAY_CYC);

	logic [3:0] pin_s;
	logic       cs_s, req_s, rd_s, wr_s;
	logic       busy_others;

	// strobes and request cross into clk before any decision
	sync2 #(.WIDTH(4), .INIT(4'hf)) u_sync (
		.clk (clk),
		.rstn(rstn),
		.d   ({chip_select_n, host_bus_request_n, host_read_n, host_write_n}),
		.q   (pin_s)
	);
	assign {cs_s, req_s, rd_s, wr_s} = pin_s;

	port_state_type state_q, state_d;
	logic [7:0]     cnt_q, cnt_d;
	logic           wr_prev_q;
	logic           sel_req, write_rise, cpa_held;

	// core priority access is only sampled; release need not meet setup
	assign cpa_held    = !core_priority_access_n; // [RQ9]
	assign busy_others = !bus_idle || cpa_held; // [RQ1]
	assign sel_req     = both_low(cs_s, req_s); // [RQ11]
	assign write_rise  = !wr_prev_q && wr_s;

	always_comb
	begin
		state_d = state_q;
		cnt_d   = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
		case (state_q)
			ST_IDLE:
				if (sel_req)
				begin
					state_d = ST_HOLD;
					cnt_d   = GR_WAIT;
				end
			ST_HOLD:
				if (!sel_req)
					state_d = ST_IDLE;
				else if (cnt_q == 8'h00 && !busy_others)
					state_d = ST_GRANT; // [RQ1] [RQ21]
			ST_GRANT:
				if (req_s)
					state_d = ST_IDLE; // [RQ21]
				else if (!rd_s && !cs_s)
				begin
					state_d = ST_RWAIT;
					cnt_d   = RD_WAIT; // [RQ14]
				end
				else if (!wr_s && !cs_s)
				begin
					state_d = ST_WWAIT;
					cnt_d   = WR_WAIT; // [RQ17]
				end
			ST_RWAIT:
				if (cnt_q == 8'h01)
					state_d = ST_DONE;
			ST_WWAIT:
				if (cnt_q <= 8'h01 && write_rise)
					state_d = ST_GRANT;
				else if (cnt_q == 8'h01)
					state_d = ST_DONE;
			ST_DONE:
				// wait for the strobe to rise before the next access
				if (rd_s && wr_s)
					state_d = ST_GRANT;
			default:
				state_d = ST_IDLE;
		endcase
	end

	logic grant_d, rdy_low_d, rdy_oe_d, ready_hi;
	assign grant_d   = state_d inside {ST_GRANT, ST_RWAIT, ST_WWAIT, ST_DONE};
	assign rdy_low_d = state_d inside {ST_HOLD, ST_RWAIT, ST_WWAIT};
	assign ready_hi  = ready_active_drive && sel_req; // [RQ13]
	// open-drain only pulls low; active drive also drives high
	assign rdy_oe_d  = rdy_low_d || ready_hi; // [RQ10] [RQ12]

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q          <= ST_IDLE;
			cnt_q            <= 8'h00;
			wr_prev_q        <= 1'b1;
			host_bus_grant_n <= `RESET_GRANT_N;
			host_ready_o     <= 1'b0;
			host_ready_oe    <= 1'b0;
		end
		else
		begin
			state_q          <= state_d;
			cnt_q            <= cnt_d;
			wr_prev_q        <= wr_s;
			host_bus_grant_n <= !grant_d; // [RQ5]
			host_ready_o     <= !rdy_low_d; // [RQ20]
			host_ready_oe    <= rdy_oe_d; // [RQ11] [RQ14] [RQ17]
		end
	end

	// pin buses delayed by two flops to line up with the synchronised strobes
	// limitation: the host must hold a word about one cycle past its strobe
	logic [AW-1:0]  addr_p1_q, addr_p2_q;
	logic [DW-1:0]  wdat_p1_q, wdat_p2_q;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			addr_p1_q <= '0;
			addr_p2_q <= '0;
			wdat_p1_q <= '0;
			wdat_p2_q <= '0;
		end
		else
		begin
			addr_p1_q <= host_addr;
			addr_p2_q <= addr_p1_q;
			wdat_p1_q <= host_wdata;
			wdat_p2_q <= wdat_p1_q;
		end
	end

	// data path: read data latched while ready is still low
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			host_rdata    <= '0;
			host_rdata_oe <= 1'b0;
			mem_rd        <= 1'b0;
			mem_wr        <= 1'b0;
			mem_addr      <= '0;
			mem_wdata     <= '0;
		end
		else
		begin
			mem_rd <= state_d == ST_RWAIT && state_q == ST_GRANT; // [RQ4]
			mem_wr <= write_rise && state_q == ST_WWAIT
				|| write_rise && state_q == ST_DONE; // [RQ19]
			if (state_q == ST_GRANT)
				mem_addr <= addr_p2_q; // [RQ4]
			else if (write_rise)
				mem_addr <= addr_p2_q; // [RQ19]
			if (write_rise)
				mem_wdata <= wdat_p2_q; // [RQ19]
			if (state_q == ST_RWAIT && cnt_q == 8'h03)
				host_rdata <= mem_rdata; // [RQ15]
			host_rdata_oe <= state_d inside {ST_RWAIT, ST_DONE} && !rd_s;
		end
	end

	a_grant_needs_req: assert property (@(posedge clk) // [RQ5]
		disable iff (!rstn) !host_bus_grant_n |-> $past(!req_s))
		else $error("grant without request");
	a_ready_low_sel: assert property (@(posedge clk) // [RQ11]
		disable iff (!rstn) $rose(sel_req) && state_q == ST_IDLE
		|=> host_ready_oe && !host_ready_o)
		else $error("ready not pulled low");
	a_read_wait_len: assert property (@(posedge clk) // [RQ14]
		disable iff (!rstn) state_q == ST_GRANT && state_d == ST_RWAIT
		|=> (!host_ready_o)[*7])
		else $error("read wait short");
	a_write_wait_len: assert property (@(posedge clk) // [RQ17]
		disable iff (!rstn) state_q == ST_GRANT && state_d == ST_WWAIT
		|=> (!host_ready_o)[*2])
		else $error("write wait short");
	a_active_off: assert property (@(posedge clk) // [RQ13]
		disable iff (!rstn) !sel_req && state_q == ST_IDLE
		&& state_d == ST_IDLE |=> !host_ready_oe)
		else $error("ready driven idle");
	a_grant_ready_up: assert property (@(posedge clk) // [RQ12]
		disable iff (!rstn) $fell(host_bus_grant_n) |-> host_ready_o)
		else $error("ready low at grant");
	a_ready_high_grant: assert property (@(posedge clk) // [RQ12]
		disable iff (!rstn) host_ready_oe && host_ready_o |-> !host_bus_grant_n)
		else $error("ready high without grant");
	a_write_capture: assert property (@(posedge clk) // [RQ19]
		disable iff (!rstn) mem_wr |-> mem_wdata == $past(host_wdata, 3))
		else $error("write data wrong");
	a_grant_drop: assert property (@(posedge clk) // [RQ21]
		disable iff (!rstn) state_q == ST_GRANT && req_s |=> host_bus_grant_n)
		else $error("grant not withdrawn");
	c_read: cover property (@(posedge clk) disable iff (!rstn)
		state_q == ST_RWAIT ##[1:20] state_q == ST_DONE);
	c_write: cover property (@(posedge clk) disable iff (!rstn) mem_wr);
	c_release: cover property (@(posedge clk) disable iff (!rstn)
		$rose(host_bus_grant_n));
endmodule : host_bus_handoff_async_port
`default_nettype wire

// ### verification/host_model.sv
// host processor model: asks for the bus, then reads and writes
// assumes the bench feeds clk, grant, resolved ready level and read data
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input  wire logic        clk,
	input  wire logic        grant_n,
	input  wire logic        ready,
	input  wire logic [47:0] rdata,
	output logic             cs_n,
	output logic             req_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic [31:0]      addr,
	output logic [47:0]      wdata
);
	initial
	begin
		{cs_n, req_n, rd_n, wr_n} = 4'hf;
		addr = 32'h0;
		wdata = 48'h0;
	end
	task automatic bus_req(input logic on);
		@(posedge clk);
		cs_n <= !on;
		req_n <= !on;
	endtask : bus_req
	// a high address bit keeps the first access out of shared space
	task automatic access(input logic rd, input logic [31:0] a,
		input logic [47:0] d, output int lo, output logic [47:0] q);
		lo = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		@(posedge clk);
		rd_n <= !rd;
		wr_n <= rd;
		for (int n = 0; n < 30; n++)
		begin
			@(posedge clk);
			if (ready === 1'b0)
				lo++;
			else if (lo > 0)
				break;
		end
		q = rdata;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		@(posedge clk);
		addr <= ~a; // hold time over: bus no longer shows the word
		wdata <= ~d;
		repeat (5) @(posedge clk);
	endtask : access
endmodule : host_model
`default_nettype wire

// ### verification/tb.sv
// self-checking bench for the host bus hand-off port
// assumes the design answers within the bounded waits used here
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk = 1'b0, rstn = 1'b0, mode = 1'b0;
	logic        cpa_n = 1'b1, idle = 1'b1;
	logic        cs_n, req_n, rd_n, wr_n, gnt_n, rdy_o, rdy_oe;
	logic        rd_oe, m_rd, m_wr, hit;
	logic [31:0] addr, m_addr, wa;
	logic [47:0] wdata, rdata, m_wdata, wd, q, m_rdata = 48'h0;
	logic        ready; // board pull-up holds a released line high
	assign ready = rdy_oe ? rdy_o : 1'b1;
	int          mismatches = 0, cmp_count = 0, cycles = 0, lo, oe_cnt = 0;
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		if (m_rd)
			m_rdata <= {16'h0, m_addr};
		if (m_wr)
			{wa, wd} <= {m_addr, m_wdata};
		if (rd_oe === 1'b1)
			oe_cnt++;
		cycles++;
		if (cycles == 4000)
		begin
			mismatches++;
			stop_test();
		end
	end
	host_model i_host_model (.clk(clk), .grant_n(gnt_n), .ready(ready),
		.rdata(rdata), .cs_n(cs_n), .req_n(req_n), .rd_n(rd_n),
		.wr_n(wr_n), .addr(addr), .wdata(wdata));
	host_bus_handoff_async_port i_host_bus_handoff_async_port (.clk(clk),
		.rstn(rstn), .chip_select_n(cs_n), .host_bus_request_n(req_n),
		.host_read_n(rd_n), .host_write_n(wr_n), .host_addr(addr),
		.host_wdata(wdata), .ready_active_drive(mode),
		.processor_bus_request_lines(4'h0),
		.core_priority_access_n(cpa_n), .bus_idle(idle),
		.host_bus_grant_n(gnt_n), .host_ready_o(rdy_o),
		.host_ready_oe(rdy_oe), .host_rdata(rdata), .host_rdata_oe(rd_oe),
		.mem_rd(m_rd), .mem_wr(m_wr), .mem_addr(m_addr),
		.mem_wdata(m_wdata), .mem_rdata(m_rdata));
	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic until_low(ref logic s, input int lim);
		hit = 1'b0;
		for (int n = 0; n < lim && !hit; n++)
		begin
			@(posedge clk);
			hit = (s === 1'b0);
		end
	endtask : until_low
	// cpa low in one style, busy bus in the other: both must hold grant
	task automatic t_grant(input logic md);
		cpa_n <= md;
		idle <= !md;
		i_host_model.bus_req(1'b1);
		until_low(ready, 10);
		check(hit && gnt_n === 1'b1, "ready not low before grant");
		repeat (20) @(posedge clk);
		check(gnt_n === 1'b1, "grant while held off");
		cpa_n <= 1'b1;
		idle <= 1'b1;
		until_low(gnt_n, 20);
		check(hit, "no grant");
		repeat (3) @(posedge clk);
		check(ready === 1'b1 && rdy_oe === md, "ready style");
		$display("grant test done");
	endtask : t_grant
	task automatic t_read(input logic [31:0] a);
		int n0;
		n0 = oe_cnt;
		i_host_model.access(1'b1, a, 48'h0, lo, q);
		check(lo >= 7, "read wait short");
		check(q === {16'h0, a}, "read data");
		check(oe_cnt > n0 && rd_oe === 1'b0, "read enable");
		$display("read test done");
	endtask : t_read
	task automatic t_write(input logic [31:0] a, input logic [47:0] d);
		i_host_model.access(1'b0, a, d, lo, q);
		check(lo >= 2, "write wait short");
		check(wa === a && wd === d, "write capture");
		$display("write test done");
	endtask : t_write
	task automatic t_release;
		i_host_model.bus_req(1'b0);
		repeat (8) @(posedge clk);
		check(gnt_n === 1'b1, "grant kept");
		check(rdy_oe === 1'b0, "ready still driven");
		$display("release test done");
	endtask : t_release
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	initial
	begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			mode <= m[0];
			t_grant(m[0]);
			t_read(32'h8000_0010);
			t_write(32'h8000_0024, 48'ha5a5_0f0f_3c3c);
			t_read(32'h8000_0024);
			t_release();
		end
		stop_test();
	end
endmodule : tb
`default_nettype wire
